/* File: hw/mcsr_regs.sv */
// status, pointer, port, power, wake-mask and pc-high registers of the core
// How it works
// - flag-affecting op on status overrides written flags
// - software writes to powerdown and watchdog flags ignored
// - clear on status gives 000u u1uu
// - status bit layout fixed as listed
// - add carry, subtract not-borrow into carry bit
// - rotate right lsb, rotate left msb into carry
// - half flag from low-nibble carry or not-borrow
// - null flag set on zero result
// - powerdown set by reset/kick, cleared by sleep
// - watchdog flag set reset/kick/sleep, cleared timeout
// - wake flag marks wake by port change
// - pointer low six bits address indirect accesses
// - pointer upper two bits read as one
// - port read returns pin levels
// - port write updates output latch only
// - port six bits, upper two read zero
// - port line three has no output drive
// - power bit five enables undervoltage detector
// - irq select routes line zero, masks change
// - irq select low blocks interrupt path
// - power bit seven enables watchdog
// - wake mask bits enable change wake per pin
// - window access redirects through pointer, self reads zero
// - dash bits read zero, asterisk bits one
`timescale 1ns/1ns
module mcsr_regs
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // datapath access
   input wire mcsr_pkg::mcsr_req_t i_req,
   input wire logic [7:0] i_ext_rdata,
   output logic [7:0] o_rdata,
   // core events
   input wire mcsr_pkg::mcsr_evt_t i_evt,
   // port pins
   input wire logic [5:0] i_port_pin,
   input wire logic [5:0] i_port_dir_in,
   output logic [5:0] o_port_out,
   output logic [5:0] o_port_oe_n,
   // control outputs
   output logic o_wdt_en,
   output logic o_uv_en,
   output logic o_ext_int,
   output logic [5:0] o_change_en,
   output logic [1:0] o_pc_hi,
   output logic o_pc_hi_stb
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] read_reg(input logic [5:0] a, input mcsr_pkg::mcsr_state_t s,
                                           input logic [5:0] pins, input logic [7:0] ext);
      logic [7:0] v;
      v = ext;
      case (a)
         mcsr_pkg::ADDR_STATUS: v = s.status;
         mcsr_pkg::ADDR_POINTER: v = mcsr_pkg::POINTER_ONES | {2'h0, s.pointer};
         mcsr_pkg::ADDR_PORT: v = {2'h0, pins};
         mcsr_pkg::ADDR_POWER: v = mcsr_pkg::POWER_ONES | {s.power, 5'h00};
         mcsr_pkg::ADDR_WAKE: v = {2'h0, s.wake_mask};
         mcsr_pkg::ADDR_PCHI: v = {6'h00, s.pc_hi};
         mcsr_pkg::ADDR_WINDOW: v = 8'h00;
         default: v = ext;
      endcase
      return v;
   endfunction

   mcsr_pkg::mcsr_state_t st;
   mcsr_pkg::mcsr_state_t next_st;
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic [5:0] eff_addr;
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] res;
      logic flags_on;
      logic [7:0] s;
      eff_addr = i_req.addr;
      sum = 9'h000;
      nib = 5'h00;
      res = 8'h00;
      flags_on = 1'b1;
      s = st.status;
      next_st = st;
      next_st.pc_hi_stb = 1'b0;
      // window redirects through the pointer; a self-pointing window is dead
      if (i_req.addr == mcsr_pkg::ADDR_WINDOW)
      begin
         eff_addr = st.pointer;
      end
      next_st.rdata = read_reg(eff_addr, st, i_port_pin, i_ext_rdata);
      // plain writes; the self-window write drops through default
      if (i_req.wr)
      begin
         case (eff_addr)
            mcsr_pkg::ADDR_STATUS:
            begin
               // flag bits 4:3 are hardware-only
               s = {i_req.wdata[7:5], st.status[4:3], i_req.wdata[2:0]};
            end
            mcsr_pkg::ADDR_POINTER: next_st.pointer = i_req.wdata[5:0];
            mcsr_pkg::ADDR_PORT: next_st.port_latch = i_req.wdata[5:0];
            mcsr_pkg::ADDR_POWER: next_st.power = i_req.wdata[7:5];
            mcsr_pkg::ADDR_WAKE: next_st.wake_mask = i_req.wdata[5:0];
            mcsr_pkg::ADDR_PCHI: next_st.pc_hi = i_req.wdata[1:0];
            default:
            begin
            end
         endcase
      end
      // alu flags win over the written value
      case (i_req.op)
         mcsr_pkg::OP_ADD:
         begin
            sum = {1'b0, i_req.opnd_a} + {1'b0, i_req.opnd_b};
            nib = {1'b0, i_req.opnd_a[3:0]} + {1'b0, i_req.opnd_b[3:0]};
            res = sum[7:0];
            s[mcsr_pkg::ST_CARRY] = sum[8];
            s[mcsr_pkg::ST_HALF] = nib[4];
         end
         mcsr_pkg::OP_SUB:
         begin
            sum = {1'b0, i_req.opnd_a} - {1'b0, i_req.opnd_b};
            nib = {1'b0, i_req.opnd_a[3:0]} - {1'b0, i_req.opnd_b[3:0]};
            res = sum[7:0];
            s[mcsr_pkg::ST_CARRY] = ~sum[8];
            s[mcsr_pkg::ST_HALF] = ~nib[4];
         end
         mcsr_pkg::OP_RR:
         begin
            s[mcsr_pkg::ST_CARRY] = i_req.opnd_a[0];
            flags_on = 1'b0;
         end
         mcsr_pkg::OP_RL:
         begin
            s[mcsr_pkg::ST_CARRY] = i_req.opnd_a[7];
            flags_on = 1'b0;
         end
         mcsr_pkg::OP_LOGIC: res = i_req.opnd_a;
         mcsr_pkg::OP_CLEAR:
         begin
            res = 8'h00;
            // clear of status itself zeroes 7:5, sets the zero flag and keeps the other flags
            if (i_req.wr && eff_addr == mcsr_pkg::ADDR_STATUS)
            begin
               s = {3'b000, st.status[4:3], 1'b1, st.status[1:0]};
            end
         end
         default: flags_on = 1'b0;
      endcase
      if (i_req.op != mcsr_pkg::OP_NONE && flags_on)
      begin
         s[mcsr_pkg::ST_ZERO] = (res == 8'h00);
      end
      // hardware reset/power events
      if (i_evt.sleep)
      begin
         s[mcsr_pkg::ST_PD] = 1'b0;
         s[mcsr_pkg::ST_TO] = 1'b1;
      end
      if (i_evt.kick)
      begin
         s[mcsr_pkg::ST_PD] = 1'b1;
         s[mcsr_pkg::ST_TO] = 1'b1;
      end
      if (i_evt.wdt_timeout && st.power[2])
      begin
         s[mcsr_pkg::ST_TO] = 1'b0;
      end
      // wake type; change wake wins if both arrive together
      if (i_evt.wake_other)
      begin
         s[mcsr_pkg::ST_WAKE] = 1'b0;
      end
      if (i_evt.wake_change)
      begin
         s[mcsr_pkg::ST_WAKE] = 1'b1;
      end
      next_st.status = s;
      // pc high is handed over when the low pc byte is written
      if (i_req.wr && eff_addr == mcsr_pkg::ADDR_PC_LOW)
      begin
         next_st.pc_hi_stb = 1'b1;
         next_st.pc_hi_load = st.pc_hi;
      end
      // pin drive from latch; line 3 never driven
      next_st.port_out = next_st.port_latch;
      next_st.port_oe_n = i_port_dir_in;
      next_st.port_out[mcsr_pkg::PORT_INPUT_ONLY] = 1'b0;
      next_st.port_oe_n[mcsr_pkg::PORT_INPUT_ONLY] = 1'b1;
      // line 0 either interrupt or plain pin
      next_st.int_line = next_st.power[1] & i_port_pin[0];
      next_st.change_en = next_st.wake_mask;
      if (next_st.power[1])
      begin
         next_st.change_en[0] = 1'b0;
      end
   end
   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st <= '0;
         st.status <= mcsr_pkg::STATUS_RST;
         st.power <= mcsr_pkg::POWER_RST[7:5];
         st.wake_mask <= mcsr_pkg::WAKE_RST[5:0];
         st.pc_hi <= mcsr_pkg::PCHI_RST;
         st.port_latch <= mcsr_pkg::PORT_RST;
         st.port_oe_n <= 6'h3F;
      end
      else
      begin
         st <= next_st;
      end
   end
   // ----------------------------------------
   // outputs, all registered
   // ----------------------------------------
   assign o_rdata = st.rdata;
   assign o_port_out = st.port_out;
   assign o_port_oe_n = st.port_oe_n;
   assign o_wdt_en = st.power[2];
   assign o_uv_en = st.power[0];
   assign o_ext_int = st.int_line;
   assign o_change_en = st.change_en;
   assign o_pc_hi = st.pc_hi_load;
   assign o_pc_hi_stb = st.pc_hi_stb;
endmodule

/* File: hw/mcsr_pkg.sv */
// package: register map, field positions, reset values, op codes and carriers
package mcsr_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [5:0] ADDR_WINDOW = 6'h00;
   localparam logic [5:0] ADDR_PC_LOW = 6'h02;
   localparam logic [5:0] ADDR_STATUS = 6'h03;
   localparam logic [5:0] ADDR_POINTER = 6'h04;
   localparam logic [5:0] ADDR_PORT = 6'h06;
   localparam logic [5:0] ADDR_POWER = 6'h08;
   localparam logic [5:0] ADDR_WAKE = 6'h09;
   localparam logic [5:0] ADDR_PCHI = 6'h0a;
   // ----------------------------------------
   // status field positions
   // ----------------------------------------
   localparam int ST_CARRY = 0;
   localparam int ST_HALF = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam int ST_WAKE = 7;
   // ----------------------------------------
   // power control field positions
   // ----------------------------------------
   localparam int PC_UV = 5;
   localparam int PC_EIS = 6;
   localparam int PC_WDT = 7;
   // ----------------------------------------
   // reset values and fixed bit patterns
   // ----------------------------------------
   localparam logic [7:0] STATUS_RST = 8'h18;
   localparam logic [7:0] POWER_RST = 8'hA0;
   localparam logic [7:0] POWER_ONES = 8'h1F;
   localparam logic [7:0] POINTER_ONES = 8'hC0;
   localparam logic [7:0] WAKE_RST = 8'h00;
   localparam logic [1:0] PCHI_RST = 2'h0;
   localparam logic [5:0] PORT_RST = 6'h00;
   localparam int PORT_INPUT_ONLY = 3;
   // ----------------------------------------
   // flag-affecting operation classes
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      OP_NONE = 3'b000,
      OP_ADD = 3'b001,
      OP_SUB = 3'b010,
      OP_RR = 3'b011,
      OP_RL = 3'b100,
      OP_LOGIC = 3'b101,
      OP_CLEAR = 3'b110
   } mcsr_op_t;
   // ----------------------------------------
   // datapath request carrier
   // ----------------------------------------
   typedef struct packed
   {
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
      mcsr_op_t op;
      logic [7:0] opnd_a;
      logic [7:0] opnd_b;
   } mcsr_req_t;
   // ----------------------------------------
   // core event carrier
   // ----------------------------------------
   typedef struct packed
   {
      logic kick;
      logic sleep;
      logic wdt_timeout;
      logic wake_change;
      logic wake_other;
   } mcsr_evt_t;
   // ----------------------------------------
   // whole register state
   // ----------------------------------------
   typedef struct packed
   {
      logic [7:0] status;
      logic [5:0] pointer;
      logic [5:0] port_latch;
      logic [2:0] power;
      logic [5:0] wake_mask;
      logic [1:0] pc_hi;
      logic [7:0] rdata;
      logic [5:0] port_out;
      logic [5:0] port_oe_n;
      logic int_line;
      logic [5:0] change_en;
      logic [1:0] pc_hi_load;
      logic pc_hi_stb;
   } mcsr_state_t;
endpackage

/* File: testbench/mcsr_properties.sv */
// checker: port-level properties of the status and control register group
`timescale 1ns/1ns
module mcsr_properties
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // datapath and events
   input wire mcsr_pkg::mcsr_req_t i_req,
   input wire logic [7:0] i_ext_rdata,
   input wire logic [7:0] o_rdata,
   input wire mcsr_pkg::mcsr_evt_t i_evt,
   // pins and controls
   input wire logic [5:0] i_port_pin,
   input wire logic [5:0] i_port_dir_in,
   input wire logic [5:0] o_port_out,
   input wire logic [5:0] o_port_oe_n,
   input wire logic o_wdt_en,
   input wire logic o_uv_en,
   input wire logic o_ext_int,
   input wire logic [5:0] o_change_en,
   input wire logic [1:0] o_pc_hi,
   input wire logic o_pc_hi_stb
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   // ----------------------------------------
   // request decode
   // ----------------------------------------
   wire w = i_req.wr;
   wire [5:0] ad = i_req.addr;
   wire rp = !w && ad == mcsr_pkg::ADDR_POINTER;
   wire rb = !w && ad == mcsr_pkg::ADDR_PORT;
   wire rw = !w && ad == mcsr_pkg::ADDR_POWER;
   wire wp = w && ad == mcsr_pkg::ADDR_POWER;
   // ----------------------------------------
   // properties
   // ----------------------------------------
   // two-edge checks: outputs may be registered from state, one edge late
   a_ptr_ones: assert property (rp |=> o_rdata[7:6] == 2'b11)
      else $error("pointer upper bits not one");
   a_port_upper: assert property (rb |=> o_rdata[7:6] == 2'b00)
      else $error("port upper bits not zero");
   a_port_pins: assert property (rb |=> o_rdata[5:0] == $past(i_port_pin))
      else $error("port read not pin level");
   a_line3_input: assert property (o_port_oe_n[3] && !o_port_out[3])
      else $error("line three driven");
   a_power_ones: assert property (rw |=> o_rdata[4:0] == 5'h1f)
      else $error("power low bits not one");
   a_wdt_follow: assert property (wp |=> o_wdt_en == $past(i_req.wdata[7]))
      else $error("watchdog enable wrong");
   a_uv_follow: assert property (wp |=> o_uv_en == $past(i_req.wdata[5]))
      else $error("undervoltage enable wrong");
   a_irq_block: assert property (wp && !i_req.wdata[6] |=> !o_ext_int)
      else $error("interrupt path open");
   a_pc_strobe: assert property (w && ad == mcsr_pkg::ADDR_PC_LOW |-> ##[1:2] o_pc_hi_stb)
      else $error("pc high strobe missing");
   c_ptr_read: cover property (rp);
   c_irq_sel: cover property (wp && i_req.wdata[6]);
   c_pc_stb: cover property (o_pc_hi_stb);
endmodule
bind mcsr_regs mcsr_properties u_props (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_req(i_req),
   .i_ext_rdata(i_ext_rdata), .o_rdata(o_rdata), .i_evt(i_evt), .i_port_pin(i_port_pin),
   .i_port_dir_in(i_port_dir_in), .o_port_out(o_port_out), .o_port_oe_n(o_port_oe_n),
   .o_wdt_en(o_wdt_en), .o_uv_en(o_uv_en), .o_ext_int(o_ext_int),
   .o_change_en(o_change_en), .o_pc_hi(o_pc_hi), .o_pc_hi_stb(o_pc_hi_stb));

/* File: testbench/mcsr_core_model.sv */
// partner: instruction datapath issuing accesses and core events
`timescale 1ns/1ns
module mcsr_core_model
(
   // clock
   input wire logic i_mclk,
   // requests and core events
   output mcsr_pkg::mcsr_req_t o_req,
   output mcsr_pkg::mcsr_evt_t o_evt,
   output logic o_rd
);
   initial
   begin
      o_req = '0;
      o_evt = '0;
      o_rd = 1'b0;
   end
   // request dropped after one edge so a write never repeats
   task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
      input mcsr_pkg::mcsr_op_t op, input logic [7:0] x, input logic [7:0] y);
      @(posedge i_mclk);
      o_req <= '{w, a, d, op, x, y};
      o_rd <= !w;
      @(posedge i_mclk);
      o_req <= '0;
      o_rd <= 1'b0;
      @(negedge i_mclk);
   endtask
   task automatic pulse(input mcsr_pkg::mcsr_evt_t e);
      @(posedge i_mclk);
      o_evt <= e;
      @(posedge i_mclk);
      o_evt <= '0;
   endtask
endmodule

/* File: testbench/tb.sv */
// testbench: drives the register group and checks reads and control outputs
`timescale 1ns/1ns
module tb;
   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [7:0] ext = 8'h00;
   logic [5:0] pins = 6'h00;
   logic [5:0] dir = 6'h00;
   mcsr_pkg::mcsr_req_t req;
   mcsr_pkg::mcsr_evt_t evt;
   mcsr_pkg::mcsr_op_t op;
   logic rd, rd_d = 1'b0, stb;
   logic [7:0] rdata, st, a, b, d;
   logic [5:0] pout, oen, chg;
   logic [1:0] pch;
   logic wdt, uv, eint;
   logic [8:0] s;
   logic [7:0] exp_q[$];
   logic [4:0] ev_tab[5] = '{5'h08, 5'h04, 5'h10, 5'h02, 5'h01};
   logic [7:0] and_tab[5] = '{8'hF7, 8'hEF, 8'hFF, 8'hFF, 8'h7F};
   logic [7:0] or_tab[5] = '{8'h10, 8'h00, 8'h18, 8'h80, 8'h00};
   int num_errors = 0;
   int total_checks = 0;
   always #20 i_mclk = ~i_mclk;
   mcsr_core_model core (.i_mclk(i_mclk), .o_req(req), .o_evt(evt), .o_rd(rd));
   mcsr_regs dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_req(req), .i_ext_rdata(ext),
      .o_rdata(rdata), .i_evt(evt), .i_port_pin(pins), .i_port_dir_in(dir),
      .o_port_out(pout), .o_port_oe_n(oen), .o_wdt_en(wdt), .o_uv_en(uv),
      .o_ext_int(eint), .o_change_en(chg), .o_pc_hi(pch), .o_pc_hi_stb(stb));
   // ----------------------------------------
   // checking
   // ----------------------------------------
   task automatic check(input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic rdx(input logic [5:0] ad, input logic [7:0] e);
      exp_q.push_back(e);
      core.access(1'b0, ad, 8'h00, mcsr_pkg::OP_NONE, 8'h00, 8'h00);
   endtask
   task automatic wrx(input logic [5:0] ad, input logic [7:0] v);
      core.access(1'b1, ad, v, mcsr_pkg::OP_NONE, 8'h00, 8'h00);
   endtask
   always @(posedge i_mclk) rd_d <= rd;
   always @(negedge i_mclk)
      if (rd_d && exp_q.size() > 0)
         check(exp_q.pop_front(), rdata);
   initial
   begin
      repeat (20000) @(posedge i_mclk);
      num_errors++;
      print_verdict();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      void'($urandom(9));
      @(posedge i_mclk);
      ext <= 8'($urandom);
      pins <= 6'($urandom);
      dir <= 6'($urandom);
      repeat (7) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      rdx(mcsr_pkg::ADDR_STATUS, 8'h18);
      rdx(mcsr_pkg::ADDR_POINTER, 8'hC0);
      rdx(mcsr_pkg::ADDR_POWER, 8'hBF);
      rdx(mcsr_pkg::ADDR_PCHI, 8'h00);
      wrx(mcsr_pkg::ADDR_STATUS, 8'h00);
      rdx(mcsr_pkg::ADDR_STATUS, 8'h18);
      wrx(mcsr_pkg::ADDR_STATUS, 8'hE7);
      rdx(mcsr_pkg::ADDR_STATUS, 8'hFF);
      core.access(1'b1, mcsr_pkg::ADDR_STATUS, 8'hFF, mcsr_pkg::OP_CLEAR, 8'h00, 8'h00);
      rdx(mcsr_pkg::ADDR_STATUS, 8'h1F);
      st = 8'h1F;
      for (int i = 0; i < 40; i++)
      begin
         a = 8'($urandom);
         b = 8'($urandom);
         d = 8'($urandom);
         op = mcsr_pkg::mcsr_op_t'(3'(i % 5 + 1));
         s = {1'b0, a} + {1'b0, b};
         case (op)
            mcsr_pkg::OP_ADD: st[2:0] = {s[7:0] == 0, ({1'b0, a[3:0]} + b[3:0]) > 15, s[8]};
            mcsr_pkg::OP_SUB: st[2:0] = {a == b, a[3:0] >= b[3:0], a >= b};
            mcsr_pkg::OP_RR: st[0] = a[0];
            mcsr_pkg::OP_RL: st[0] = a[7];
            default: st[2] = a == 8'h00;
         endcase
         // only add and subtract aim at status: other ops leave flag writes open
         if (i % 2 == 1 && op <= mcsr_pkg::OP_SUB)
         begin
            core.access(1'b1, mcsr_pkg::ADDR_STATUS, d, op, a, b);
            st[7:5] = d[7:5];
         end
         else
            core.access(1'b1, 6'h10, d, op, a, b);
         rdx(mcsr_pkg::ADDR_STATUS, st);
      end
      for (int j = 0; j < 5; j++)
      begin
         core.pulse(ev_tab[j]);
         st = (st & and_tab[j]) | or_tab[j];
         rdx(mcsr_pkg::ADDR_STATUS, st);
      end
      wrx(mcsr_pkg::ADDR_POINTER, 8'h10);
      rdx(mcsr_pkg::ADDR_POINTER, 8'hD0);
      rdx(mcsr_pkg::ADDR_WINDOW, ext);
      wrx(mcsr_pkg::ADDR_POINTER, 8'h09);
      wrx(mcsr_pkg::ADDR_WINDOW, 8'h3F);
      rdx(mcsr_pkg::ADDR_WAKE, 8'h3F);
      wrx(mcsr_pkg::ADDR_POINTER, 8'h00);
      rdx(mcsr_pkg::ADDR_WINDOW, 8'h00);
      wrx(mcsr_pkg::ADDR_WINDOW, 8'hFF);
      rdx(mcsr_pkg::ADDR_POINTER, 8'hC0);
      wrx(mcsr_pkg::ADDR_PORT, 8'hFF);
      rdx(mcsr_pkg::ADDR_PORT, {2'b00, pins});
      check(8'h37, {2'b00, pout});
      check({2'b00, dir | 6'h08}, {2'b00, oen});
      check(8'h3F, {2'b00, chg});
      wrx(mcsr_pkg::ADDR_POWER, 8'h40);
      rdx(mcsr_pkg::ADDR_POWER, 8'h5F);
      check(8'h3E, {2'b00, chg});
      check({7'h00, pins[0]}, {7'h00, eint});
      check(8'h00, {6'h00, wdt, uv});
      wrx(mcsr_pkg::ADDR_POWER, 8'hA0);
      rdx(mcsr_pkg::ADDR_WAKE, 8'h3F);
      check(8'h03, {6'h00, wdt, uv});
      check(8'h00, {7'h00, eint});
      wrx(mcsr_pkg::ADDR_PCHI, 8'hFF);
      rdx(mcsr_pkg::ADDR_PCHI, 8'h03);
      wrx(mcsr_pkg::ADDR_PC_LOW, 8'h00);
      check(8'h07, {5'h00, stb, pch});
      repeat (4) @(posedge i_mclk);
      print_verdict();
   end
endmodule
